// file: core/aicr_core.sv
// I2C target command layer: commands, result readout and config registers.
`timescale 1ns/100ps
`include "aicr_cfg.svh"

module aicr_core #(
	parameter logic [6:0] DEV_ADDR   = 7'h40,
	parameter int         RES_WIDTH  = 24,
	parameter int         BUF_DEPTH  = 2
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst_b,
	input  wire logic                   ce,
	input  wire logic                   sclIn,
	input  wire logic                   sdaIn,
	output      logic                   sdaOut,
	output      logic                   sdaOeN,
	input  wire logic [RES_WIDTH-1:0]   resultData,
	input  wire logic                   resultValid,
	output      logic                   resultReady,
	output      logic                   drdyN,
	output      logic                   convRestart,
	output      logic [7:0]             cfgInputGain,
	output      logic [7:0]             cfgRateMode,
	output      logic [7:0]             cfgStatus,
	output      logic [7:0]             cfgRouting,
	output      aicr_pkg::aicr_link_t   linkState
);
	import aicr_pkg::*;

	localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [15:0] crcByte(input logic [15:0] crc,
		input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {b, 8'h00};
		for (int k = 0; k < 8; k++) begin
			c = c[15] ? ((c << 1) ^ `AICR_CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

	function automatic logic [PTR_W-1:0] ptrInc(input logic [PTR_W-1:0] p);
		return (p == PTR_W'(BUF_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic sclMeta;
	logic sclSync;
	logic sclPrev;
	logic sdaMeta;
	logic sdaSync;
	logic sdaPrev;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclMeta <= 1'b1;
			sclSync <= 1'b1;
			sclPrev <= 1'b1;
			sdaMeta <= 1'b1;
			sdaSync <= 1'b1;
			sdaPrev <= 1'b1;
		end else if (ce) begin
			sclMeta <= sclIn;
			sclSync <= sclMeta;
			sclPrev <= sclSync;
			sdaMeta <= sdaIn;
			sdaSync <= sdaMeta;
			sdaPrev <= sdaSync;
		end
	end

	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	assign sclRise   = sclSync & ~sclPrev;
	assign sclFall   = ~sclSync & sclPrev;
	assign startSeen = sclSync & sclPrev & sdaPrev & ~sdaSync;
	assign stopSeen  = sclSync & sclPrev & ~sdaPrev & sdaSync;

	// ----------------------------------------------------------------
	// Result buffer
	// ----------------------------------------------------------------
	// Results are held back while a read frame is open, so that a word
	// finishing mid-transfer waits here instead of being dropped.
	logic [RES_WIDTH-1:0] bufMem [0:BUF_DEPTH-1];
	logic [PTR_W-1:0]     wrPtr;
	logic [PTR_W-1:0]     rdPtr;
	logic [PTR_W:0]       bufCount;
	logic                 bufPush;
	logic                 bufPop;
	logic [PTR_W:0]       next_bufCount;

	assign bufPush = resultValid & resultReady;
	assign bufPop  = (bufCount != '0) & (linkState != LINK_READ);
	always_comb begin
		next_bufCount = bufCount;
		if (bufPush && !bufPop) begin
			next_bufCount = bufCount + 1'b1;
		end else if (bufPop && !bufPush) begin
			next_bufCount = bufCount - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (ce && bufPush) begin
			bufMem[wrPtr] <= resultData;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr       <= '0;
			rdPtr       <= '0;
			bufCount    <= '0;
			resultReady <= 1'b1;
		end else if (ce) begin
			if (bufPush) begin
				wrPtr <= ptrInc(wrPtr);
			end
			if (bufPop) begin
				rdPtr <= ptrInc(rdPtr);
			end
			bufCount    <= next_bufCount;
			resultReady <= next_bufCount < (PTR_W+1)'(BUF_DEPTH);
		end
	end

	// ----------------------------------------------------------------
	// Latest result, counter word and new-result indication
	// ----------------------------------------------------------------
	logic [RES_WIDTH-1:0] latest;
	logic [7:0]           convCounter;
	logic                 newFlag;
	logic                 fetchCmd;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			latest      <= '0;
			convCounter <= 8'h00;
		end else if (ce && bufPop) begin
			latest      <= bufMem[rdPtr];
			convCounter <= convCounter + 8'h01; // R12
		end
	end

	// One event drives both the pin and the status bit; a new result in
	// the same cycle as a fetch keeps the flag set.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			newFlag <= 1'b0;
			drdyN   <= 1'b1;
		end else if (ce) begin
			if (bufPop) begin
				newFlag <= 1'b1; // R9 R21
				drdyN   <= 1'b0; // R8 R21
			end else if (fetchCmd) begin
				newFlag <= 1'b0;
				drdyN   <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Byte engine on the link
	// ----------------------------------------------------------------
	logic [3:0] bitCnt;
	logic [7:0] shiftIn;
	logic [7:0] txShift;
	logic [2:0] txIdx;
	logic       masterAck;
	logic       byteDone;
	logic [7:0] resp [0:`AICR_RESP_MAX-1];
	logic [3:0] respLen;
	logic [7:0] nextTx;

	// Eighth falling edge of a byte in a write frame.
	assign byteDone = sclFall & (bitCnt == 4'd7) & (linkState == LINK_WRITE);
	// Past the prepared response, within the first 8 bytes of a frame, the device sends the idle byte, driven
	// bit for bit like any other byte so that it reads back as stored.
	assign nextTx = ({1'b0, txIdx} < respLen) ? resp[txIdx]
		: `AICR_IDLE_BYTE;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			linkState <= LINK_IDLE;
			bitCnt    <= 4'd0;
			shiftIn   <= 8'h00;
			txShift   <= 8'h00;
			txIdx     <= 3'd0;
			masterAck <= 1'b0;
			sdaOeN    <= 1'b1;
			sdaOut    <= 1'b0;
		end else if (ce) begin
			if (startSeen) begin
				// The SCL fall that closes START is not a data bit, so the
				// count starts one below zero and that fall wraps it to 0.
				linkState <= LINK_ADDR;
				bitCnt    <= 4'hf;
				sdaOeN    <= 1'b1;
			end else if (stopSeen) begin
				linkState <= LINK_IDLE;
				sdaOeN    <= 1'b1;
			end else if (linkState != LINK_IDLE) begin
				if (sclRise) begin
					if (bitCnt < 4'd8) begin
						shiftIn <= {shiftIn[6:0], sdaSync};
					end else if (linkState == LINK_READ) begin
						masterAck <= ~sdaSync;
					end
				end else if (sclFall) begin
					if (bitCnt == 4'd7) begin
						bitCnt <= 4'd8;
						case (linkState)
							LINK_ADDR: begin
								if (shiftIn[7:1] == DEV_ADDR) begin
									sdaOeN    <= 1'b0;
									txIdx     <= 3'd0;
									linkState <= shiftIn[0] ? LINK_READ
										: LINK_WRITE; // R2 R4
								end else begin
									linkState <= LINK_IDLE;
								end
							end
							LINK_WRITE: sdaOeN <= 1'b0; // R6
							default: sdaOeN <= 1'b1;
						endcase
					end else if (bitCnt == 4'd8) begin
						bitCnt <= 4'd0;
						if (linkState == LINK_READ && masterAck) begin
							txShift <= nextTx; // R3 R13
							sdaOeN  <= nextTx[7];
							txIdx   <= txIdx + 3'd1;
						end else begin
							sdaOeN <= 1'b1;
							if (linkState == LINK_READ) begin
								linkState <= LINK_IDLE;
							end
						end
					end else begin
						bitCnt <= bitCnt + 4'd1;
						if (linkState == LINK_READ) begin
							txShift <= {txShift[6:0], 1'b0};
							sdaOeN  <= txShift[6];
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Command decode and configuration registers
	// ----------------------------------------------------------------
	logic [7:0]  cfgRegs [0:3];
	logic        expectData;
	logic [1:0]  wrAddr;
	logic [3:0]  opcode;
	logic [1:0]  cmdAddr;

	assign opcode   = shiftIn[7:4];
	assign cmdAddr  = shiftIn[3:2]; // R20
	assign fetchCmd = byteDone & ~expectData
		& (opcode == `AICR_OPC_FETCH); // R19

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 4; i++) begin
				cfgRegs[i] <= `AICR_REG_RESET; // R17
			end
			expectData  <= 1'b0;
			wrAddr      <= 2'd0;
			convRestart <= 1'b0;
		end else if (ce) begin
			convRestart <= 1'b0;
			if (startSeen || stopSeen) begin
				expectData <= 1'b0;
			end else if (byteDone) begin // R19
				if (expectData) begin
					// The new-result bit is read-only; its stored copy stays 0.
					cfgRegs[wrAddr] <= (wrAddr == `AICR_OFS_STATUS)
						? (shiftIn & ~(8'h01 << `AICR_NEW_RESULT_BIT))
						: shiftIn; // R5 R16 R18
					expectData      <= 1'b0;
					convRestart     <= 1'b1; // R7
				end else if (opcode == `AICR_OPC_WRITE) begin
					expectData <= 1'b1;
					wrAddr     <= cmdAddr;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Response builder
	// ----------------------------------------------------------------
	logic [7:0]       dat [0:3];
	logic [2:0]       datLen;
	logic [15:0]      crc;
	logic [7:0]       nextResp [0:`AICR_RESP_MAX-1];
	logic [3:0]       nextLen;
	logic             cntEn;
	aicr_integ_t      integ;
	logic [7:0]       readVal;

	assign cntEn = cfgRegs[`AICR_OFS_STATUS][`AICR_COUNTER_EN_BIT];
	assign integ = aicr_integ_t'({cfgRegs[`AICR_OFS_STATUS][`AICR_INTEG_HI_BIT],
		cfgRegs[`AICR_OFS_STATUS][`AICR_INTEG_LO_BIT]});

	always_comb begin
		readVal = cfgRegs[cmdAddr];
		if (cmdAddr == `AICR_OFS_STATUS) begin
			readVal[`AICR_NEW_RESULT_BIT] = newFlag; // R9
		end else if (cmdAddr == `AICR_OFS_ROUTING) begin
			readVal = readVal & `AICR_ROUTING_ZERO;
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			dat[i] = 8'h00;
		end
		datLen = 3'd1;
		if (opcode == `AICR_OPC_FETCH) begin
			datLen = cntEn ? 3'd4 : 3'd3;
			dat[0] = cntEn ? convCounter : latest[23:16]; // R12
			dat[1] = cntEn ? latest[23:16] : latest[15:8];
			dat[2] = cntEn ? latest[15:8] : latest[7:0];
			dat[3] = latest[7:0];
		end else begin
			dat[0] = readVal; // R4
		end
		crc = `AICR_CRC_INIT;
		for (int i = 0; i < `AICR_RESP_MAX; i++) begin
			nextResp[i] = 8'h00;
		end
		for (int i = 0; i < 4; i++) begin
			if (3'(i) < datLen) begin
				nextResp[i] = dat[i];
				crc         = crcByte(crc, dat[i]);
			end
		end
		nextLen = {1'b0, datLen};
		case (integ)
			INTEG_INVERTED: begin
				for (int i = 0; i < 4; i++) begin
					if (3'(i) < datLen) begin
						nextResp[i + 4'(datLen)] = ~dat[i]; // R15
					end
				end
				nextLen = {datLen, 1'b0};
			end
			INTEG_CRC16: begin
				nextResp[datLen]       = crc[15:8]; // R14
				nextResp[datLen + 3'd1] = crc[7:0];
				nextLen                = 4'(datLen) + 4'd2;
			end
			default: nextLen = {1'b0, datLen};
		endcase
	end

	// Loaded only by a command byte, so later results cannot disturb it.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < `AICR_RESP_MAX; i++) begin
				resp[i] <= 8'h00;
			end
			respLen <= 4'd0;
		end else if (ce && byteDone && !expectData
			&& (opcode == `AICR_OPC_FETCH || opcode == `AICR_OPC_READ)) begin
			for (int i = 0; i < `AICR_RESP_MAX; i++) begin
				resp[i] <= nextResp[i]; // R1 R11 R13
			end
			respLen <= nextLen;
		end
	end

	// ----------------------------------------------------------------
	// Register outputs
	// ----------------------------------------------------------------
	always_comb begin
		cfgInputGain = cfgRegs[`AICR_OFS_INPUT_GAIN];
		cfgRateMode  = cfgRegs[`AICR_OFS_RATE_MODE];
		cfgStatus    = cfgRegs[`AICR_OFS_STATUS];
		cfgRouting   = cfgRegs[`AICR_OFS_ROUTING];
	end
endmodule

// file: core/aicr_cfg.svh
// Register offsets, field positions, reset values and command codes.
//
// How it works
// [R1] A fetch command copies the newest finished result into the output shifter.
// [R2] Host writes the fetch command in one frame, then reads in another.
// [R3] The read frame after a fetch shifts the latest result out on SDA.
// [R4] Register read command names a register; next read frame returns it.
// [R5] Register write command plus one data byte stores that byte.
// [R6] Several write command and data pairs may share one write frame.
// [R7] Every register write pulses filter reset and conversion restart.
// [R8] Data-ready pin goes low when a new result is available.
// [R9] The new-result status bit in register 2 sets on each new result.
// [R10] Host polls at least as fast as the conversion rate.
// [R11] A result arriving mid-transfer never changes bytes already loaded.
// [R12] Counter word increments per new result; host discards repeats.
// [R13] Selected integrity words follow the data bytes directly.
// [R14] Checksum mode appends exactly two bytes after every response.
// [R15] Inverted-copy mode adds three bytes to results, four with counter.
// [R16] Four 8-bit registers reachable only through the two commands.
// [R17] All registers are zero after reset.
// [R18] Power-down leaves every register untouched.
// [R19] A command byte acts only on its eighth falling SCL edge.
// [R20] Register address is bits 3:2; don't-care bits are ignored.
// [R21] Pin and status bit come from the same new-result event.
`ifndef AICR_CFG_SVH
`define AICR_CFG_SVH

`define AICR_OFS_INPUT_GAIN   2'h0
`define AICR_OFS_RATE_MODE    2'h1
`define AICR_OFS_STATUS       2'h2
`define AICR_OFS_ROUTING      2'h3
`define AICR_REG_RESET        8'h00
`define AICR_NEW_RESULT_BIT   7
`define AICR_COUNTER_EN_BIT   6
`define AICR_INTEG_HI_BIT     5
`define AICR_INTEG_LO_BIT     4
`define AICR_ROUTING_ZERO     8'hfc
`define AICR_OPC_FETCH        4'h1
`define AICR_OPC_READ         4'h2
`define AICR_OPC_WRITE        4'h4
`define AICR_CRC_INIT         16'hffff
`define AICR_CRC_POLY         16'h1021
`define AICR_IDLE_BYTE        8'h00
`define AICR_RESP_MAX         8

`endif

// file: core/aicr_pkg.sv
// Types shared by the command and readout block.
package aicr_pkg;
	typedef enum logic [1:0] {
		LINK_IDLE,
		LINK_ADDR,
		LINK_WRITE,
		LINK_READ
	} aicr_link_t;

	typedef enum logic [1:0] {
		INTEG_NONE,
		INTEG_INVERTED,
		INTEG_CRC16,
		INTEG_RESERVED
	} aicr_integ_t;
endpackage

// file: bench/aicr_core_properties.sv
// Port-level assertions for the command and readout block.
`timescale 1ns/100ps

module aicr_core_properties (
	input wire logic                 core_clk,
	input wire logic                 rst_b,
	input wire logic                 ce,
	input wire logic                 resultValid,
	input wire logic                 resultReady,
	input wire logic                 sdaOeN,
	input wire logic                 drdyN,
	input wire logic                 convRestart,
	input wire logic [7:0]           cfgInputGain,
	input wire logic [7:0]           cfgRateMode,
	input wire logic [7:0]           cfgStatus,
	input wire logic [7:0]           cfgRouting,
	input wire aicr_pkg::aicr_link_t linkState
);
	import aicr_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	wire [31:0] cfgAll = {cfgInputGain, cfgRateMode, cfgStatus, cfgRouting};

	sequence taken_s;
		resultValid && resultReady && ce && linkState == LINK_IDLE;
	endsequence
	sequence stay_read_s;
		(linkState == LINK_READ)[*3];
	endsequence
	sequence idle_two_s;
		(linkState == LINK_IDLE)[*2];
	endsequence

	restart_pulse_a: assert property (
		convRestart |=> !convRestart) else $error("restart pulse too long");
	write_restart_a: assert property (
		$changed(cfgAll) |-> convRestart)
		else $error("register write without restart");
	write_frame_a: assert property (
		$changed(cfgAll) |-> $past(linkState) == LINK_WRITE)
		else $error("register changed outside a write frame");
	new_result_flag_set_a: assert property (
		taken_s ##1 (linkState == LINK_IDLE && ce) |=> !drdyN)
		else $error("data ready did not fall");
	new_result_flag_clear_a: assert property (
		$rose(drdyN) |-> $past(linkState) == LINK_WRITE)
		else $error("data ready rose outside a write frame");
	read_hold_a: assert property (
		stay_read_s |-> !$fell(drdyN) && !$rose(resultReady))
		else $error("result taken during a read frame");
	idle_release_a: assert property (
		idle_two_s |-> sdaOeN) else $error("SDA pulled while idle");
	freeze_a: assert property (
		!ce |=> $stable(cfgAll) && $stable(drdyN) && $stable(linkState))
		else $error("state moved while disabled");
endmodule

bind aicr_core aicr_core_properties props_i (.core_clk(core_clk),
	.rst_b(rst_b), .ce(ce), .resultValid(resultValid),
	.resultReady(resultReady), .sdaOeN(sdaOeN), .drdyN(drdyN),
	.convRestart(convRestart), .cfgInputGain(cfgInputGain),
	.cfgRateMode(cfgRateMode), .cfgStatus(cfgStatus),
	.cfgRouting(cfgRouting), .linkState(linkState));

// file: bench/aicr_i2c_host.sv
// Behavioural I2C host: drives SCL and pulls SDA low, never high.
`timescale 1ns/100ps

module aicr_i2c_host (
	output logic      scl,
	output logic      pullLow,
	input  wire logic sda
);
	localparam real Q = 31.25;

	// SCL stands high between frames; nothing here runs free.
	initial begin
		scl = 1'b1;
		pullLow = 1'b0;
	end

	task automatic start();
		pullLow = 1'b0;
		#Q scl = 1'b1;
		#Q pullLow = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask

	task automatic stop();
		pullLow = 1'b1;
		#Q scl = 1'b1;
		#Q pullLow = 1'b0;
		#Q;
	endtask

	task automatic bit_cycle(input logic low, output logic seen);
		pullLow = low;
		#Q scl = 1'b1;
		#Q seen = sda;
		#Q scl = 1'b0;
		#Q;
	endtask

	// Reading is sending 8'hff, which leaves SDA to the device.
	task automatic xfer(input logic [7:0] wb, input logic hostAck,
		output logic [7:0] rb, output logic ackBit);
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(!wb[i], rb[i]);
		end
		bit_cycle(hostAck, ackBit);
	endtask
endmodule

// file: bench/aicr_core_bench.sv
// Self-checking bench for the command and readout block.
`timescale 1ns/100ps

module aicr_core_bench;
	import aicr_pkg::*;
	logic        core_clk, rst_b, ce, resultValid, scl, pullLow;
	logic [23:0] resultData, latest;
	logic        sdaOut, sdaOeN, resultReady, drdyN, convRestart, ack;
	logic [7:0]  cfgInputGain, cfgRateMode, cfgStatus, cfgRouting;
	logic [7:0]  rb, cnt, st;
	logic [7:0]  d [4];
	aicr_link_t  linkState;
	logic [31:0] seed = 32'h0000597e;
	int          miscompares = 0;
	int          compares = 0;
	int          cycles = 0;
	int          restarts = 0;
	wire         sda = !(pullLow || (!sdaOeN && !sdaOut));
	wire [31:0]  cfgAll = {cfgInputGain, cfgRateMode, cfgStatus, cfgRouting};
	localparam logic [7:0] MODES [5] = '{8'h00, 8'h50, 8'h10, 8'h20, 8'h70};

	aicr_core DUT (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
		.sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
		.resultData(resultData), .resultValid(resultValid),
		.resultReady(resultReady), .drdyN(drdyN), .convRestart(convRestart),
		.cfgInputGain(cfgInputGain), .cfgRateMode(cfgRateMode),
		.cfgStatus(cfgStatus), .cfgRouting(cfgRouting), .linkState(linkState));
	aicr_i2c_host host (.scl(scl), .pullLow(pullLow), .sda(sda));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Response byte i of a fetch, for status setting s.
	function automatic logic [7:0] resp(input logic [7:0] s, input int i);
		logic [7:0]  b [8];
		logic [31:0] full;
		logic [15:0] crc;
		int          n;
		full = {cnt, latest};
		crc = 16'hffff;
		n = s[6] ? 4 : 3;
		for (int k = 0; k < 8; k++) begin
			b[k] = (k < n) ? full[8*(n-1-k) +: 8] : 8'h00;
		end
		if (s[5:4] == 2'h1) begin
			for (int k = 0; k < n; k++) begin
				b[n+k] = ~b[k];
			end
		end else if (s[5:4] == 2'h2) begin
			for (int k = 0; k < n; k++) begin
				for (int j = 7; j >= 0; j--) begin
					crc = {crc[14:0], 1'b0} ^
						((crc[15] ^ b[k][j]) ? 16'h1021 : 16'h0000);
				end
			end
			b[n] = crc[15:8];
			b[n+1] = crc[7:0];
		end
		return b[i];
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		if (miscompares == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 90000) begin
			miscompares++;
			stop_test();
		end
	end

	always @(posedge core_clk) begin
		if (convRestart === 1'b1) begin
			restarts++;
		end
	end

	// ----------------------------------------------------------------
	// Frame helpers
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] b);
		host.xfer(b, 1'b0, rb, ack);
		check(ack, 1'b0);
	endtask

	task automatic open(input logic rw);
		host.start();
		wr({7'h40, rw});
	endtask

	task automatic wr_pair(input logic [1:0] r, input logic [7:0] v);
		wr({4'h4, r, 2'(rnd())});
		wr(v);
	endtask

	task automatic reg_read(input logic [1:0] r, input logic [7:0] exp);
		open(1'b0);
		wr({4'h2, r, 2'(rnd())});
		host.stop();
		open(1'b1);
		host.xfer(8'hff, 1'b0, rb, ack);
		check(rb, exp);
		host.stop();
	endtask

	task automatic push(input logic [23:0] w);
		@(negedge core_clk);
		resultData = w;
		resultValid = 1'b1;
		repeat (100) begin
			@(posedge core_clk);
			if (resultReady === 1'b1) break;
		end
		@(negedge core_clk);
		resultValid = 1'b0;
		cnt++;
		latest = w;
	endtask

	// A word pushed in mid-read must not leak into the bytes on the wire.
	task automatic fetch(input logic [7:0] s);
		logic [7:0] e [8];
		for (int i = 0; i < 8; i++) begin
			e[i] = resp(s, i);
		end
		open(1'b0);
		wr({4'h1, 4'(rnd())});
		host.stop();
		check(drdyN, 1'b1);
		open(1'b1);
		for (int i = 0; i < 8; i++) begin
			host.xfer(8'hff, i != 7, rb, ack);
			check(rb, e[i]);
			if (i == 0) push(24'(rnd()));
			if (i == 1) check(drdyN, 1'b1);
		end
		host.stop();
	endtask

	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		resultValid = 1'b0;
		resultData = 24'h000000;
		cnt = 8'h00;
		latest = 24'h000000;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		rst_b = 1'b1;
		@(negedge core_clk);
		check(cfgAll, 32'h00000000);
		check({drdyN, resultReady}, 2'b11);
		check({sdaOut, sdaOeN, linkState}, {2'b01, LINK_IDLE});
		open(1'b0);
		for (int r = 0; r < 4; r++) begin
			d[r] = 8'(rnd());
			wr_pair(2'(r), d[r]);
		end
		host.stop();
		d[2][7] = 1'b0;
		check(cfgAll, {d[0], d[1], d[2], d[3]});
		check(restarts, 4);
		for (int r = 0; r < 4; r++) begin
			reg_read(2'(r), (r == 3) ? d[3] & 8'hfc : d[r]);
		end
		open(1'b0);
		wr(8'h8c);
		host.stop();
		@(negedge core_clk);
		ce = 1'b0;
		repeat (20) @(negedge core_clk);
		ce = 1'b1;
		check(cfgAll, {d[0], d[1], d[2], d[3]});
		check(restarts, 4);
		foreach (MODES[m]) begin
			st = MODES[m] | (8'(rnd()) & 8'h0f);
			open(1'b0);
			wr_pair(2'h2, st);
			host.stop();
			check(restarts, 5 + m);
			push(24'(rnd()));
			repeat (3) @(negedge core_clk);
			check(drdyN, 1'b0);
			reg_read(2'h2, st | 8'h80);
			fetch(st);
		end
		stop_test();
	end
endmodule
